// File: rtl/i2c_access_sequencer.sv
// I2C master sequencer for memories and four-register expanders
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_map.svh"
module i2c_access_sequencer
#(
  parameter int MEM_DEPTH      = `MEM_DEPTH_DEF,
  parameter int WR_WAIT_CYCLES = `WR_CYCLE_CYC,
  parameter int QTR_CYCLES     = `SCL_QTR_CYC
)
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Requests
  input  wire logic                req_valid,
  input  wire i2c_seq_pkg::op_type req_op,
  input  wire logic [7:0]          req_addr,
  input  wire logic [7:0]          req_data,
  input  wire logic [6:0]          slave_addr,
  input  wire logic                auto_set,
  // Status and returned data
  output logic                     req_ready,
  output logic                     op_done,
  output logic                     op_error,
  output logic                     verify_error,
  output logic                     auto_on,
  output logic                     resp_valid,
  output logic [7:0]               resp_addr,
  output logic [7:0]               resp_data,
  // I2C pins
  input  wire logic                scl_in,
  output logic                     scl_out,
  output logic                     scl_oe,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe
);
  import i2c_seq_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH);
  localparam int CW = 9;
  localparam int QW = $clog2(QTR_CYCLES + 1);
  localparam int WW = $clog2(WR_WAIT_CYCLES + 1);

  if (MEM_DEPTH < 4 || MEM_DEPTH > 256 || (1 << AW) != MEM_DEPTH ||
      QTR_CYCLES < 1 || WR_WAIT_CYCLES < 1)
  begin : g_bad_param
    $error("i2c_access_sequencer: unsupported parameter values");
  end

  function automatic logic [CW-1:0] txn_len(input logic rd, input logic ex,
                                             input op_type op, input logic [CW-1:0] tot);
    txn_len = CW'(1);
    if (rd && !ex)
      txn_len = tot;
    else if (op == OP_WRITE_ALL && !ex)
      txn_len = (tot > CW'(`PAGE_BYTES)) ? CW'(`PAGE_BYTES) : tot;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic scl_m_reg;
  logic scl_s_reg;
  logic sda_m_reg;
  logic sda_s_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end
    else
    begin
      scl_m_reg <= scl_in;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= sda_in;
      sda_s_reg <= sda_m_reg;
    end
  end

  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  eng_state_type eng_reg;
  logic [QW-1:0] qcnt_reg;
  logic [1:0]    q_reg;
  logic [3:0]    bit_reg;
  logic [8:0]    sh_reg;
  logic [8:0]    rx_reg;
  logic          eng_done_reg;
  logic          scl_oe_reg;
  logic          sda_oe_reg;
  logic          go;
  eng_state_type go_kind;
  logic [8:0]    go_tx;
  logic          tick;
  logic          hold;

  assign tick = (qcnt_reg == QW'(QTR_CYCLES - 1));
  // Target may stretch the clock while high phase is pending
  assign hold = (q_reg == 2'd2) && !scl_s_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eng_reg      <= E_IDLE;
      qcnt_reg     <= '0;
      q_reg        <= 2'd0;
      bit_reg      <= 4'h0;
      sh_reg       <= 9'h1ff;
      rx_reg       <= 9'h1ff;
      eng_done_reg <= 1'b0;
      scl_oe_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end
    else
    begin
      eng_done_reg <= 1'b0;
      case (eng_reg)
        E_IDLE:
          if (go)
          begin
            eng_reg  <= go_kind;
            sh_reg   <= go_tx;
            q_reg    <= 2'd0;
            bit_reg  <= 4'h0;
            qcnt_reg <= '0;
          end
        default:
          if (!tick)
            qcnt_reg <= qcnt_reg + QW'(1);
          else if (!hold)
          begin
            qcnt_reg <= '0;
            q_reg    <= q_reg + 2'd1;
            case (q_reg)
              2'd0:
                sda_oe_reg <= (eng_reg == E_STOP) ||
                              (eng_reg == E_BYTE && !sh_reg[8]);
              2'd1:
                scl_oe_reg <= 1'b0;
              2'd2:
                if (eng_reg == E_BYTE)
                  rx_reg <= {rx_reg[7:0], sda_s_reg};
                else
                  sda_oe_reg <= (eng_reg == E_START);
              default:
              begin
                // Clock stays low after start and bytes until a stop [RL15]
                if (eng_reg != E_STOP)
                  scl_oe_reg <= 1'b1;
                sh_reg  <= {sh_reg[7:0], 1'b1};
                bit_reg <= bit_reg + 4'h1;
                if (eng_reg != E_BYTE || bit_reg == 4'h8)
                begin
                  eng_reg      <= E_IDLE;
                  eng_done_reg <= 1'b1;
                end
              end
            endcase
          end
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_type st_reg;
  op_type        op_reg;
  logic [7:0]    ptr_reg;
  logic [7:0]    data_reg;
  logic [CW-1:0] tot_reg;
  logic [CW-1:0] left_reg;
  logic [WW-1:0] wcnt_reg;
  logic          rd_reg;
  logic          exp_mode_reg;
  logic          phase_rd_reg;
  logic          verify_reg;
  logic          auto_tx_reg;
  logic          wait_reg;
  logic          err_reg;
  logic          vfy_err_reg;
  logic          done_reg;
  logic          ready_reg;
  logic          auto_on_reg;
  logic          resp_valid_reg;
  logic [7:0]    resp_addr_reg;
  logic [7:0]    resp_data_reg;
  logic [7:0]    exp_regs [`EXP_REG_COUNT];
  logic [7:0]    mem [MEM_DEPTH];
  logic          step;
  logic          last;
  logic          bus_state;
  logic [1:0]    idx;
  logic [7:0]    rx_byte;
  logic [7:0]    wr_byte;
  logic          mem_we;
  logic [AW-1:0] mem_wa;
  logic [7:0]    mem_wd;

  assign step      = wait_reg && eng_done_reg;
  assign last      = (left_reg == CW'(1));
  assign idx       = req_addr[1:0];
  assign rx_byte   = rx_reg[8:1];
  assign wr_byte   = exp_mode_reg ? exp_regs[ptr_reg[1:0]] : mem[ptr_reg[AW-1:0]];
  assign bus_state = (st_reg == S_START) || (st_reg == S_SADDR) || (st_reg == S_WADDR) ||
                     (st_reg == S_DATA_W) || (st_reg == S_DATA_R) || (st_reg == S_STOP);
  assign go        = bus_state && !wait_reg;

  always_comb
  begin
    go_kind = E_BYTE;
    go_tx   = {wr_byte, 1'b1};
    case (st_reg)
      S_START:  go_kind = E_START;
      S_STOP:   go_kind = E_STOP;
      S_SADDR:  go_tx   = {slave_addr, phase_rd_reg, 1'b1};  // [RL1]
      S_WADDR:  go_tx   = {ptr_reg, 1'b1};                   // [RL1]
      S_DATA_R: go_tx   = {8'hff, last};
      default:  go_tx   = {wr_byte, 1'b1};
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wait_reg <= 1'b0;
    else if (go)
      wait_reg <= 1'b1;
    else if (eng_done_reg)
      wait_reg <= 1'b0;
  end

  // Local buffer writes; a fill never reaches the bus [RL8]
  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = ptr_reg[AW-1:0];
    mem_wd = rx_byte;
    if (st_reg == S_IDLE && req_valid && req_op == OP_WRITE_BYTE)
    begin
      mem_we = 1'b1;
      mem_wa = req_addr[AW-1:0];
      mem_wd = req_data;
    end
    else if (st_reg == S_FILL)
    begin
      mem_we = 1'b1;
      mem_wd = data_reg;
    end
    else if (st_reg == S_DATA_R && step && !exp_mode_reg && !verify_reg)
      mem_we = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < `EXP_REG_COUNT; i++)
        exp_regs[i] <= 8'h00;
    end
    else if (st_reg == S_IDLE && req_valid && req_op == OP_EXP_SET && idx != 2'd0)
      exp_regs[idx] <= req_data;  // [RL10]
    else if (st_reg == S_DATA_R && step && exp_mode_reg)
      exp_regs[ptr_reg[1:0]] <= rx_byte;
  end

  // Immediate mode: request wins over the hardware clear [RL14]
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      auto_on_reg <= 1'b0;
    else if (auto_set)
      auto_on_reg <= 1'b1;
    else if (st_reg == S_NEXT && auto_tx_reg && err_reg)
      auto_on_reg <= 1'b0;  // [RL14]
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg         <= S_IDLE;
      op_reg         <= OP_READ_BYTE;
      ptr_reg        <= 8'h00;
      data_reg       <= 8'h00;
      tot_reg        <= '0;
      left_reg       <= '0;
      wcnt_reg       <= '0;
      rd_reg         <= 1'b0;
      exp_mode_reg   <= 1'b0;
      phase_rd_reg   <= 1'b0;
      verify_reg     <= 1'b0;
      auto_tx_reg    <= 1'b0;
      err_reg        <= 1'b0;
      vfy_err_reg    <= 1'b0;
      done_reg       <= 1'b0;
      ready_reg      <= 1'b1;
      resp_valid_reg <= 1'b0;
      resp_addr_reg  <= 8'h00;
      resp_data_reg  <= 8'h00;
    end
    else
    begin
      done_reg       <= 1'b0;
      resp_valid_reg <= 1'b0;
      case (st_reg)
        S_IDLE:
          if (req_valid)
          begin
            ready_reg    <= 1'b0;
            op_reg       <= req_op;
            data_reg     <= req_data;
            err_reg      <= 1'b0;
            vfy_err_reg  <= 1'b0;
            verify_reg   <= 1'b0;
            auto_tx_reg  <= 1'b0;
            phase_rd_reg <= 1'b0;
            exp_mode_reg <= 1'b0;
            rd_reg       <= 1'b0;
            ptr_reg      <= 8'(`MEM_START);
            tot_reg      <= CW'(MEM_DEPTH);
            st_reg       <= S_START;
            case (req_op)
              OP_READ_BYTE:
              begin
                ptr_reg <= req_addr;  // [RL2]
                tot_reg <= CW'(1);
                rd_reg  <= 1'b1;
              end
              OP_READ_ALL:
                rd_reg <= 1'b1;  // [RL3]
              OP_WRITE_BYTE:
              begin
                ptr_reg <= req_addr;  // [RL4]
                tot_reg <= CW'(1);
              end
              OP_WRITE_ALL:
                rd_reg <= 1'b0;  // [RL5]
              OP_FILL:
                st_reg <= S_FILL;  // [RL8]
              OP_EXP_READ_ALL:
              begin
                exp_mode_reg <= 1'b1;
                rd_reg       <= 1'b1;
                tot_reg      <= CW'(`EXP_REG_COUNT);  // [RL11]
              end
              OP_EXP_WRITE_ALL:
              begin
                exp_mode_reg <= 1'b1;
                ptr_reg      <= 8'(`EXP_FIRST_WR);  // [RL10] [RL12]
                tot_reg      <= CW'(`EXP_REG_COUNT - `EXP_FIRST_WR);
              end
              OP_EXP_SET:
              begin
                exp_mode_reg <= 1'b1;
                auto_tx_reg  <= 1'b1;
                ptr_reg      <= {6'h00, idx};
                tot_reg      <= CW'(1);
                // Only a changed register 1..3 in immediate mode goes out [RL13]
                if (idx == 2'd0 || !auto_on_reg || req_data == exp_regs[idx])
                begin
                  tot_reg <= '0;
                  st_reg  <= S_NEXT;
                end
              end
              default:
              begin
                tot_reg <= '0;
                st_reg  <= S_NEXT;
              end
            endcase
          end
        S_FILL:
        begin
          ptr_reg <= ptr_reg + 8'h01;
          tot_reg <= tot_reg - CW'(1);
          if (tot_reg == CW'(1))
            st_reg <= S_NEXT;
        end
        S_START:
          if (step)
            st_reg <= S_SADDR;
        S_SADDR:
          if (step)
          begin
            if (rx_reg[0])
            begin
              err_reg <= 1'b1;  // [RL16]
              st_reg  <= S_STOP;
            end
            else
              st_reg <= phase_rd_reg ? S_DATA_R : S_WADDR;
          end
        S_WADDR:
          if (step)
          begin
            left_reg <= txn_len(rd_reg, exp_mode_reg, op_reg, tot_reg);  // [RL5]
            if (rx_reg[0])
            begin
              err_reg <= 1'b1;  // [RL16]
              st_reg  <= S_STOP;
            end
            else if (rd_reg)
            begin
              phase_rd_reg <= 1'b1;  // [RL2] [RL15]
              st_reg       <= S_START;
            end
            else
              st_reg <= S_DATA_W;
          end
        S_DATA_W:
          if (step)
          begin
            if (rx_reg[0])
            begin
              err_reg <= 1'b1;  // [RL16]
              st_reg  <= S_STOP;
            end
            else
            begin
              ptr_reg  <= ptr_reg + 8'h01;
              tot_reg  <= tot_reg - CW'(1);
              left_reg <= left_reg - CW'(1);
              if (last)
                st_reg <= S_STOP;  // [RL5]
            end
          end
        S_DATA_R:
          if (step)
          begin
            ptr_reg  <= ptr_reg + 8'h01;
            tot_reg  <= tot_reg - CW'(1);
            left_reg <= left_reg - CW'(1);
            if (verify_reg)
            begin
              if (rx_byte != mem[ptr_reg[AW-1:0]])
                vfy_err_reg <= 1'b1;  // [RL7]
            end
            else
            begin
              resp_valid_reg <= 1'b1;  // [RL2]
              resp_addr_reg  <= ptr_reg;
              resp_data_reg  <= rx_byte;
            end
            if (last)
              st_reg <= S_STOP;
          end
        S_STOP:
          if (step)
            st_reg <= S_NEXT;
        S_NEXT:
        begin
          phase_rd_reg <= 1'b0;
          wcnt_reg     <= '0;
          if (!err_reg && op_reg == OP_WRITE_ALL && !verify_reg)
            st_reg <= S_WAIT;  // [RL6]
          else if (!err_reg && tot_reg != '0)
            st_reg <= S_START;  // [RL11] [RL12]
          else
          begin
            done_reg  <= 1'b1;
            ready_reg <= 1'b1;
            st_reg    <= S_IDLE;
          end
        end
        S_WAIT:
        begin
          wcnt_reg <= wcnt_reg + WW'(1);
          if (wcnt_reg == WW'(WR_WAIT_CYCLES - 1))
          begin
            st_reg <= S_START;  // [RL6]
            if (tot_reg == '0)
            begin
              verify_reg <= 1'b1;  // [RL7]
              rd_reg     <= 1'b1;
              ptr_reg    <= 8'(`MEM_START);
              tot_reg    <= CW'(MEM_DEPTH);
            end
          end
        end
        default:
          st_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready    = ready_reg;
  assign op_done      = done_reg;
  assign op_error     = err_reg;
  assign verify_error = vfy_err_reg;
  assign auto_on      = auto_on_reg;
  assign resp_valid   = resp_valid_reg;
  assign resp_addr    = resp_addr_reg;
  assign resp_data    = resp_data_reg;
  assign scl_oe       = scl_oe_reg;
  assign sda_oe       = sda_oe_reg;
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;

endmodule
`default_nettype wire

// File: rtl/i2c_seq_map.svh
// Constants of the I2C access sequencer
// Notes on behaviour
// RL1 - Send slave address, then word address, then the data.
// RL2 - Byte read: write word address, repeated start, read one byte, return it.
// RL3 - Read all: word address 0, repeated start, read the whole device.
// RL4 - Byte write: slave address, word address, one data byte.
// RL5 - Write all from address 0, four-byte pages, each page ends in stop.
// RL6 - Wait out the target erase/write cycle before the next page.
// RL7 - After write all, read back everything and flag any mismatch.
// RL8 - Buffer fill touches local storage only, no bus activity.
// RL9 - Expander has four readable registers; register 0 is read-only.
// RL10 - Never write expander register 0; only 1 to 3.
// RL11 - Expander read all: one transaction per register, 0 through 3.
// RL12 - Expander write all: registers 1, 2, 3, each with its own start.
// RL13 - Immediate mode: changed register 1 to 3 is written at once.
// RL14 - Failed immediate write turns immediate mode off until re-enabled.
// RL15 - A transaction left without stop keeps clock low; next uses repeated start.
// RL16 - Missing acknowledge aborts, sends stop, reports an error.
`ifndef I2C_SEQ_MAP_SVH
`define I2C_SEQ_MAP_SVH

`define CLK_PERIOD_NS 100
`define SCL_QTR_NS    2500
`define SCL_QTR_CYC   ((`SCL_QTR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WR_CYCLE_US   5000
`define WR_CYCLE_CYC  ((`WR_CYCLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAGE_BYTES    4
`define MEM_START     0
`define MEM_DEPTH_DEF 256
`define EXP_REG_COUNT 4
`define EXP_FIRST_WR  1

`endif

// File: rtl/i2c_seq_pkg.sv
// Types of the I2C access sequencer
package i2c_seq_pkg;

  typedef enum logic [3:0]
  {
    OP_READ_BYTE     = 4'h0,
    OP_READ_ALL      = 4'h1,
    OP_WRITE_BYTE    = 4'h2,
    OP_WRITE_ALL     = 4'h3,
    OP_FILL          = 4'h4,
    OP_EXP_READ_ALL  = 4'h5,
    OP_EXP_WRITE_ALL = 4'h6,
    OP_EXP_SET       = 4'h7
  } op_type;

  typedef enum logic [9:0]
  {
    S_IDLE   = 10'h001,
    S_FILL   = 10'h002,
    S_START  = 10'h004,
    S_SADDR  = 10'h008,
    S_WADDR  = 10'h010,
    S_DATA_W = 10'h020,
    S_DATA_R = 10'h040,
    S_STOP   = 10'h080,
    S_NEXT   = 10'h100,
    S_WAIT   = 10'h200
  } seq_state_type;

  typedef enum logic [3:0]
  {
    E_IDLE  = 4'h1,
    E_START = 4'h2,
    E_BYTE  = 4'h4,
    E_STOP  = 4'h8
  } eng_state_type;

endpackage

// File: testbench/i2c_access_sequencer_monitor.sv
// Port-level assertions of the I2C access sequencer
`timescale 1ns/1ps
`default_nettype none
module i2c_access_sequencer_monitor
#(
  parameter int MEM_DEPTH = 16
)
(
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                req_valid,
  input wire i2c_seq_pkg::op_type req_op,
  input wire logic [7:0]          req_addr,
  input wire logic                auto_set,
  input wire logic                req_ready,
  input wire logic                op_done,
  input wire logic                op_error,
  input wire logic                verify_error,
  input wire logic                auto_on,
  input wire logic                resp_valid,
  input wire logic [7:0]          resp_addr,
  input wire logic                scl_oe,
  input wire logic                sda_oe
);
  import i2c_seq_pkg::*;
  op_type last_op;
  logic   quiet;
  int     cyc;
  int     rcnt;
  // ----------------------------------------
  // Operation tracking
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      last_op <= OP_READ_BYTE;
      quiet   <= 1'b0;
      cyc     <= 0;
      rcnt    <= 0;
    end
    else if (req_valid && req_ready)
    begin
      last_op <= req_op;
      quiet   <= req_op == OP_FILL || (req_op == OP_EXP_SET && (req_addr[1:0] == 2'h0 || !auto_on));
      cyc     <= 0;
      rcnt    <= 0;
    end
    else
    begin
      cyc  <= cyc + 1;
      rcnt <= rcnt + (resp_valid ? 1 : 0);
      if (op_done)
        quiet <= 1'b0;
    end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_bus_free;
    !scl_oe && !sda_oe;
  endsequence
  sequence s_end_ok;
    op_done && !op_error;
  endsequence
  a_take_busy: assert property (s_take |=> !req_ready)
    else $error("ready stayed high after a request");
  a_quiet_ops: assert property (quiet |-> s_bus_free)
    else $error("bus moved during a local-only operation");
  a_fill_length: assert property (op_done && last_op == OP_FILL |-> cyc == MEM_DEPTH + 1)
    else $error("fill took the wrong number of cycles");
  a_read_one: assert property (s_end_ok ##0 last_op == OP_READ_BYTE |-> rcnt == 1)
    else $error("byte read returned other than one byte");
  a_read_all: assert property (s_end_ok ##0 last_op == OP_READ_ALL |-> rcnt == MEM_DEPTH)
    else $error("read all returned wrong byte count");
  a_exp_reads: assert property (s_end_ok ##0 last_op == OP_EXP_READ_ALL |-> rcnt == 4)
    else $error("expander read all returned wrong count");
  a_resp_order: assert property (
    resp_valid && last_op inside {OP_READ_ALL, OP_EXP_READ_ALL} |-> resp_addr == 8'(rcnt))
    else $error("read data out of address order");
  a_verify_src: assert property (verify_error |-> last_op == OP_WRITE_ALL)
    else $error("verify flag outside a write all");
  a_auto_win: assert property (auto_set |=> auto_on)
    else $error("immediate mode not turned on");
  a_auto_hold: assert property (!auto_on && !auto_set |=> !auto_on)
    else $error("immediate mode came on by itself");
  a_auto_drop: assert property ($fell(auto_on) |-> op_error)
    else $error("immediate mode dropped without a failure");
  a_done_free: assert property (op_done |-> s_bus_free)
    else $error("bus still held at operation end");
endmodule

bind i2c_access_sequencer i2c_access_sequencer_monitor #(.MEM_DEPTH(MEM_DEPTH)) MON
  (.clk, .rst_b, .req_valid, .req_op, .req_addr, .auto_set, .req_ready, .op_done, .op_error,
   .verify_error, .auto_on, .resp_valid, .resp_addr, .scl_oe, .sda_oe);
`default_nettype wire

// File: testbench/i2c_mem_model.sv
// Behavioural I2C memory and four-register expander target
`timescale 1ns/1ps
`default_nettype none
module i2c_mem_model
#(
  parameter logic [6:0] SLV     = 7'h2a,
  parameter int         BUSY_NS = 1900
)
(
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic nack_en,
  input  wire logic exp_mode,
  input  wire logic corrupt,
  output logic      sda_pull
);
  logic [7:0] mem [256];
  logic [7:0] sh;
  logic [7:0] ptr;
  int         cnt;
  int         ph;
  logic       act;
  logic       rd;
  logic       wr;
  logic       wr0;
  realtime    busy_end;
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    sda_pull = 1'b0;
    act      = 1'b0;
    wr       = 1'b0;
    wr0      = 1'b0;
    busy_end = 0;
  end
  // ----------------------------------------
  // Start and stop detection
  // ----------------------------------------
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1'b1;
      cnt = 0;
      ph  = 0;
      rd  = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1 && act)
    begin
      act = 1'b0;
      if (wr && !exp_mode)
        busy_end = $realtime + BUSY_NS;
      wr = 1'b0;
    end
  // ----------------------------------------
  // Bit engine
  // ----------------------------------------
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (rd && sda)
        act = 1'b0;
      cnt = (cnt == 8) ? 0 : cnt + 1;
    end
  always @(negedge scl)
    if (act)
    begin
      sda_pull = 1'b0;
      if (cnt == 8 && (ph == 0 || !rd))
      begin
        sda_pull = !nack_en && (ph != 0 || (sh[7:1] == SLV && $realtime >= busy_end));
        if (ph == 0)
          rd = sh[0];
        else if (ph == 1)
          ptr = sh;
        else if (exp_mode && ptr == 8'h00)
          wr0 = 1'b1;
        else
        begin
          mem[ptr] = sh;
          ptr      = ptr + 8'h01;
          wr       = 1'b1;
        end
        if (ph < 2)
          ph = ph + 1;
      end
      else if (rd && cnt < 8)
        sda_pull = !(mem[ptr][7 - cnt] ^ corrupt);
      else if (rd)
        ptr = ptr + 8'h01;
    end
endmodule
`default_nettype wire

// File: testbench/i2c_access_sequencer_test.sv
// Self-checking bench of the I2C access sequencer
`timescale 1ns/1ps
`default_nettype none
module i2c_access_sequencer_test;
  import i2c_seq_pkg::*;
  localparam int DEPTH = 16;
  logic        clk, rst_b, req_valid, auto_set, req_ready, op_done, op_error, verify_error;
  logic        auto_on, resp_valid, scl_oe, sda_oe, scl_out, sda_out;
  logic        nack_en, exp_mode, corrupt, sda_pull, scl, sda;
  op_type      req_op;
  logic [7:0]  req_addr, req_data, resp_addr, resp_data, v;
  logic [7:0]  ex [4];
  logic [15:0] rq [$];
  logic [1:0]  fq [$];
  int          failures, check_count;
  assign scl = ~scl_oe;
  assign sda = ~(sda_oe | sda_pull);
  i2c_access_sequencer #(.MEM_DEPTH(DEPTH), .WR_WAIT_CYCLES(20), .QTR_CYCLES(2)) DUT
  (
    .clk, .rst_b, .req_valid, .req_op, .req_addr, .req_data, .slave_addr(7'h2a), .auto_set,
    .req_ready, .op_done, .op_error, .verify_error, .auto_on, .resp_valid, .resp_addr,
    .resp_data, .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe
  );
  i2c_mem_model #(.SLV(7'h2a)) PEER (.scl, .sda, .nack_en, .exp_mode, .corrupt, .sda_pull);
  // ----------------------------------------
  // Clock, checking and closing
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic run(input op_type op, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] fl);
    int n;
    fq.push_back(fl);
    @(negedge clk);
    req_op    = op;
    req_addr  = a;
    req_data  = d;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 20000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 20000)
      failures++;
    repeat (30) @(negedge clk);
  endtask
  always @(posedge clk)
  begin
    if (resp_valid === 1'b1)
      chk({resp_addr, resp_data}, rq.size() > 0 ? rq.pop_front() : 16'hxxxx);
    if (op_done === 1'b1)
      chk({op_error, verify_error}, fq.pop_front());
  end
  initial
  begin
    #4000000;
    failures++;
    test_done;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    {rst_b, req_valid, auto_set, nack_en, exp_mode, corrupt} = 6'h00;
    {req_addr, req_data} = 16'h0000;
    req_op      = OP_READ_BYTE;
    failures    = 0;
    check_count = 0;
    void'($urandom(32'h23162d8d));
    repeat (4) @(negedge clk);
    chk(16'({req_ready, op_done, op_error, verify_error, auto_on, resp_valid, scl_oe,
             sda_oe, scl_out, sda_out}), 16'h200);
    rst_b = 1'b1;
    v = 8'($urandom);
    run(OP_FILL, 8'h00, v, 2'b00);
    run(OP_WRITE_ALL, 8'h00, 8'h00, 2'b00);
    for (int i = 0; i <= DEPTH; i++)
      chk(16'(PEER.mem[i]), i < DEPTH ? 16'(v) : 16'h0);
    $display("test fill and write all done");
    for (int i = 0; i < DEPTH; i++)
    begin
      PEER.mem[i] = 8'($urandom);
      rq.push_back({8'(i), PEER.mem[i]});
    end
    run(OP_READ_ALL, 8'h00, 8'h00, 2'b00);
    v = 8'($urandom_range(DEPTH - 1));
    run(OP_WRITE_BYTE, v, 8'h3c ^ v, 2'b00);
    chk(16'(PEER.mem[v]), 16'(8'h3c ^ v));
    rq.push_back({v, 8'h3c ^ v});
    run(OP_READ_BYTE, v, 8'h00, 2'b00);
    $display("test memory reads and byte write done");
    corrupt = 1'b1;
    run(OP_WRITE_ALL, 8'h00, 8'h00, 2'b01);
    corrupt = 1'b0;
    nack_en = 1'b1;
    run(OP_READ_BYTE, 8'h00, 8'h00, 2'b10);
    nack_en = 1'b0;
    $display("test verify and refusal done");
    exp_mode = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      PEER.mem[i] = 8'($urandom);
      rq.push_back({8'(i), PEER.mem[i]});
    end
    run(OP_EXP_READ_ALL, 8'h00, 8'h00, 2'b00);
    v = PEER.mem[1];
    run(OP_EXP_SET, 8'h01, v ^ 8'h5a, 2'b00);
    chk(16'(PEER.mem[1]), 16'(v));
    @(negedge clk);
    auto_set = 1'b1;
    @(negedge clk);
    auto_set = 1'b0;
    chk(16'(auto_on), 16'h1);
    for (int i = 1; i < 4; i++)
    begin
      ex[i] = ~PEER.mem[i];
      run(OP_EXP_SET, 8'(i), ex[i], 2'b00);
      chk(16'(PEER.mem[i]), 16'(ex[i]));
      PEER.mem[i] = ~ex[i];
    end
    run(OP_EXP_SET, 8'h00, 8'ha5, 2'b00);
    run(OP_EXP_WRITE_ALL, 8'h00, 8'h00, 2'b00);
    for (int i = 1; i < 4; i++)
      chk(16'(PEER.mem[i]), 16'(ex[i]));
    chk(16'(PEER.wr0), 16'h0);
    nack_en = 1'b1;
    run(OP_EXP_SET, 8'h02, ~ex[2], 2'b10);
    nack_en = 1'b0;
    chk(16'(auto_on), 16'h0);
    run(OP_EXP_SET, 8'h03, ~ex[3], 2'b00);
    chk(16'(PEER.mem[3]), 16'(ex[3]));
    chk(16'(rq.size()), 16'h0);
    $display("test expander done");
    test_done;
  end
endmodule
`default_nettype wire
